// ### verilog/cpplr_pkg.sv
package cpplr_pkg;

    localparam int unsigned CPPLR_PORTS = 4;
    localparam int unsigned CPPLR_SEL_W = 2;

    // register indices on the management bus
    localparam logic [7:0] CPPLR_IDX_ROUTE = 8'h00;
    localparam logic [7:0] CPPLR_IDX_CTRL = 8'h03;
    localparam logic [7:0] CPPLR_IDX_STATUS = 8'h04;

    // control register fields
    localparam int unsigned CPPLR_KEEP_LSB = 0;
    localparam int unsigned CPPLR_SPARE_LSB = 4;
    localparam int unsigned CPPLR_MON_BIT = 6;
    localparam int unsigned CPPLR_SWON_BIT = 7;

    // reset values
    localparam logic [7:0] CPPLR_CTRL_RST = 8'h0f;
    localparam logic [7:0] CPPLR_ROUTE_RST = 8'h00;
    localparam logic [3:0] CPPLR_STATUS_RST = 4'h0;
    localparam logic [3:0] CPPLR_RSVD_READ = 4'h0;
    localparam logic [7:0] CPPLR_UNMAPPED_READ = 8'h00;

    // one register access from the bus protocol engine
    typedef struct packed {
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } cpplr_req_t;

    // enables handed to the analog datapath
    typedef struct packed {
        logic power_up;
        logic monitor_on;
        logic [3:0] output_en;
        logic [3:0] input_en;
    } cpplr_pwr_t;

endpackage

// ### verilog/cpplr_regs.sv
// What this block does
// (R1) keep bits in control 3:0, reset to ones; a zero powers its output down
// (R2) keep bits only act while power pin or software power bit is high
// (R3) monitor enable in control bit 6, reset 0, turns on all input monitors
// (R4) with monitor enable set, trimming never disables an input or monitor
// (R5) software power bit in control bit 7, reset 0; zero asks power-down
// (R6) power-down only when software bit and power pin are both 0
// (R7) power-down stops all but monitors and bus slave, registers reachable
// (R8) monitor enable turns monitors on even in power-down
// (R9) in power-up, trimming powers down what the routing leaves unused
// (R10) output enabled only when routing needs it and its keep bit is 1
// (R11) input enabled when monitor enable is 1, or in power-up when routing needs it
// (R12) read-only status bits 3:0 report inputs 0..3, 1 valid, reset 0
// (R13) status bits 7:4 reserved, read-only, value undefined
// (R14) control at register index 3, status at index 4
// (R15) routing byte: two-bit selector per output, output 0 in 1:0, reset 00
// (R16) control bits 5:4 plain storage with no effect
`timescale 1ns/100ps
`default_nettype none

module cpplr_regs
    import cpplr_pkg::*;
#(
    parameter int unsigned PORTS = CPPLR_PORTS
)
(
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic ce,
    // register access from the bus protocol engine
    input wire cpplr_pkg::cpplr_req_t reg_req,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // pins and analog detectors
    input wire logic power_down_pin,
    input wire logic [3:0] signal_present,
    // enables to the datapath
    output cpplr_pkg::cpplr_pwr_t pwr
);
    import cpplr_pkg::*;

    // the routing byte only has room for four selectors
    if (PORTS != CPPLR_PORTS)
    begin
        $error("cpplr_regs serves exactly four ports");
    end

    ////////////////////////////////////////////////////////////////////////
    // inputs needed by the routing
    function automatic logic [3:0] needed_inputs(input logic [7:0] route);
        logic [3:0] hit;
        hit = 4'h0;
        for (int o = 0; o < CPPLR_PORTS; o++)
            hit[route[o*CPPLR_SEL_W +: CPPLR_SEL_W]] = 1'h1;
        return hit;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // pin synchronisers: both sources are asynchronous to clk
    logic pin_meta_r;
    logic pin_sync_r;
    logic [3:0] present_meta_r;
    logic [3:0] present_sync_r;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pin_meta_r <= 1'h0;
            pin_sync_r <= 1'h0;
            present_meta_r <= 4'h0;
            present_sync_r <= 4'h0;
        end
        else if (ce)
        begin
            pin_meta_r <= power_down_pin;
            pin_sync_r <= pin_meta_r;
            present_meta_r <= signal_present;
            present_sync_r <= present_meta_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register decode
    logic [7:0] ctrl_r;
    logic [7:0] route_r;
    logic [3:0] status_r;
    logic [3:0] status_nxt;
    logic [7:0] reg_rdata_r;
    logic reg_rvalid_r;

    // (R14) index decode
    wire logic hit_ctrl = reg_req.addr == CPPLR_IDX_CTRL;
    wire logic hit_status = reg_req.addr == CPPLR_IDX_STATUS;
    wire logic hit_route = reg_req.addr == CPPLR_IDX_ROUTE;
    wire logic wr_ctrl = reg_req.wr && hit_ctrl;
    wire logic wr_route = reg_req.wr && hit_route;

    // (R13) reserved upper status bits read back as zero
    wire logic [7:0] status_word = {CPPLR_RSVD_READ, status_r};
    wire logic [7:0] rd_mux = hit_ctrl ? ctrl_r :
                              hit_status ? status_word :
                              hit_route ? route_r : CPPLR_UNMAPPED_READ;

    wire logic [3:0] keep_w = ctrl_r[CPPLR_KEEP_LSB +: 4];
    wire logic mon_w = ctrl_r[CPPLR_MON_BIT];
    wire logic swon_w = ctrl_r[CPPLR_SWON_BIT];

    ////////////////////////////////////////////////////////////////////////
    // power mode and trimming
    // (R6) pin or software bit
    wire logic power_up_w = pin_sync_r | swon_w;
    wire logic [3:0] in_need_w = needed_inputs(route_r);
    // every output carries a selector, so routing always drives all four
    wire logic [3:0] out_need_w = 4'hf;
    // (R2) (R10) keep bits gated by mode
    wire logic [3:0] oe_nxt = power_up_w ? (out_need_w & keep_w) : 4'h0;
    // (R4) (R8) (R9) (R11) monitors override trimming in either mode
    wire logic [3:0] ie_nxt = mon_w ? 4'hf :
                              (power_up_w ? in_need_w : 4'h0);

    ////////////////////////////////////////////////////////////////////////
    // registers; (R7) bus path runs regardless of power mode
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            // (R1) (R3) (R5) (R16) control reset
            ctrl_r <= CPPLR_CTRL_RST;
            // (R15) routing reset
            route_r <= CPPLR_ROUTE_RST;
            reg_rdata_r <= CPPLR_UNMAPPED_READ;
            reg_rvalid_r <= 1'h0;
        end
        else if (ce)
        begin
            if (wr_ctrl)
                ctrl_r <= reg_req.wdata;
            if (wr_route)
                route_r <= reg_req.wdata;
            reg_rvalid_r <= reg_req.rd;
            if (reg_req.rd)
                reg_rdata_r <= rd_mux;
        end
    end

    // (R12) an input reads valid only while its monitor is powered
    assign status_nxt = present_sync_r & pwr.input_en;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            status_r <= CPPLR_STATUS_RST;
            pwr <= '0;
        end
        else if (ce)
        begin
            status_r <= status_nxt;
            pwr.power_up <= power_up_w;
            pwr.monitor_on <= mon_w;
            pwr.output_en <= oe_nxt;
            pwr.input_en <= ie_nxt;
        end
    end

    assign reg_rdata = reg_rdata_r;
    assign reg_rvalid = reg_rvalid_r;

    ////////////////////////////////////////////////////////////////////////
    // checks
    chk_keep_reset: assert property (@(posedge clk) // (R1)
        $fell(sys_rst) |-> ctrl_r == CPPLR_CTRL_RST)
        else $error("control not at reset value");

    chk_down_outputs: assert property (@(posedge clk) // (R2)
        disable iff (sys_rst)
        (ce && !pin_sync_r && !swon_w) |=> pwr.output_en == 4'h0)
        else $error("output on in power-down");

    chk_keep_gates: assert property (@(posedge clk) // (R10)
        disable iff (sys_rst)
        (ce && power_up_w) |=> pwr.output_en == $past(keep_w))
        else $error("output enable does not follow keep bits");

    chk_monitor_all: assert property (@(posedge clk) // (R8)
        disable iff (sys_rst)
        (ce && mon_w) |=> pwr.input_en == 4'hf)
        else $error("monitor enable left an input off");

    chk_trim_inputs: assert property (@(posedge clk) // (R9)
        disable iff (sys_rst)
        (ce && !mon_w && power_up_w) |=> pwr.input_en == $past(in_need_w))
        else $error("trimming mismatch on inputs");

    chk_down_inputs: assert property (@(posedge clk) // (R7)
        disable iff (sys_rst)
        (ce && !mon_w && !power_up_w) |=> pwr.input_en == 4'h0)
        else $error("input on in power-down without monitors");

    chk_mode_or: assert property (@(posedge clk) // (R6)
        disable iff (sys_rst)
        (ce && $past(ce) && pin_sync_r) |=> pwr.power_up)
        else $error("power pin high but not powered up");

    chk_ctrl_write: assert property (@(posedge clk) // (R14)
        disable iff (sys_rst)
        (ce && reg_req.wr && reg_req.addr == CPPLR_IDX_CTRL) |=>
            ctrl_r == $past(reg_req.wdata))
        else $error("control write lost");

    chk_status_read: assert property (@(posedge clk) // (R13)
        disable iff (sys_rst)
        (ce && reg_req.rd && reg_req.addr == CPPLR_IDX_STATUS) |=>
            reg_rvalid && reg_rdata[7:4] == CPPLR_RSVD_READ &&
            reg_rdata[3:0] == $past(status_r))
        else $error("status read wrong");

    chk_status_valid: assert property (@(posedge clk) // (R12)
        disable iff (sys_rst)
        (ce && $past(ce)) |-> ((status_r & ~$past(pwr.input_en)) == 4'h0))
        else $error("status valid on a powered-down input");

    cov_power_down: cover property (@(posedge clk) disable iff (sys_rst)
        $fell(pwr.power_up));
    cov_monitor_down: cover property (@(posedge clk) disable iff (sys_rst)
        pwr.monitor_on && !pwr.power_up && status_r != 4'h0);
    cov_trimmed: cover property (@(posedge clk) disable iff (sys_rst)
        pwr.power_up && !pwr.monitor_on && pwr.input_en != 4'hf);

endmodule

`default_nettype wire

// ### verif/cpplr_far_model.sv
`timescale 1ns/100ps
`default_nettype none

module cpplr_far_model
    import cpplr_pkg::*;
(
    // cable state from the bench
    input wire logic [3:0] cable_ok,
    // enables from the block
    input wire cpplr_pkg::cpplr_pwr_t pwr,
    // detector outputs
    output logic [3:0] signal_present
);
    import cpplr_pkg::*;

    // an unpowered receiver never reports a signal
    assign signal_present = cable_ok & pwr.input_en;
endmodule

`default_nettype wire

// ### verif/testbench.sv
`timescale 1ns/100ps
`default_nettype none

module testbench;
    import cpplr_pkg::*;
    logic clk = 1'h0;
    logic sys_rst = 1'h1;
    logic ce = 1'h1;
    logic pin = 1'h0;
    logic [7:0] want;
    logic [3:0] cable_ok = 4'h0;
    logic [3:0] present;
    cpplr_req_t req = '0;
    logic [7:0] rdata;
    logic rvalid;
    cpplr_pwr_t pwr;
    cpplr_pwr_t e;
    int errors = 0;
    int checked = 0;
    logic [7:0] ctrl;
    logic [7:0] route;
    logic [7:0] got;
    ////////////////////////////////////////////////////////////////////////
    initial forever #10 clk = ~clk;
    cpplr_regs dut_u (.clk(clk), .sys_rst(sys_rst), .ce(ce),
        .reg_req(req), .reg_rdata(rdata), .reg_rvalid(rvalid),
        .power_down_pin(pin), .signal_present(present), .pwr(pwr));
    cpplr_far_model far_u (.cable_ok(cable_ok), .pwr(pwr),
        .signal_present(present));
    ////////////////////////////////////////////////////////////////////////
    function automatic cpplr_pwr_t exp_pwr(input logic [7:0] c,
        input logic [7:0] r, input logic p);
        cpplr_pwr_t x;
        logic [3:0] need;
        need = 4'h0;
        for (int i = 0; i < 4; i++)
        begin
            need[r[2*i +: 2]] = 1'b1;
        end
        x.power_up = p | c[CPPLR_SWON_BIT];
        x.monitor_on = c[CPPLR_MON_BIT];
        x.output_en = x.power_up ? c[3:0] : 4'h0;
        x.input_en = x.monitor_on ? 4'hf : (x.power_up ? need : 4'h0);
        return x;
    endfunction

    task automatic cmp_byte(input logic [7:0] g, input logic [7:0] x);
        checked++;
        if (g !== x)
        begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, x);
        end
    endtask

    task automatic cmp_pwr(input cpplr_pwr_t g, input cpplr_pwr_t x);
        checked++;
        if (g !== x)
        begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, g, x);
        end
    endtask

    // one strobe, taken at the next edge, answer checked just after it
    task automatic access(input logic [7:0] a, input logic w,
        input logic [7:0] d);
        @(posedge clk);
        req <= '{addr: a, wr: w, rd: !w, wdata: d};
        @(posedge clk);
        req <= '0;
        #1;
        got = rdata;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] x);
        access(a, 1'h0, 8'h00);
        cmp_byte({7'h0, rvalid}, 8'h01);
        cmp_byte(got, x);
    endtask

    task automatic close_out;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        void'($urandom(44));
        repeat (20) @(posedge clk);
        sys_rst <= 1'h0;
        rd_chk(CPPLR_IDX_CTRL, CPPLR_CTRL_RST);
        want = {CPPLR_RSVD_READ, CPPLR_STATUS_RST};
        rd_chk(CPPLR_IDX_STATUS, want);
        rd_chk(CPPLR_IDX_ROUTE, CPPLR_ROUTE_RST);
        rd_chk(8'h07, CPPLR_UNMAPPED_READ);
        $display("test reset values done");
        for (int n = 0; n < 200; n++)
        begin
            ctrl = 8'($urandom);
            route = 8'($urandom);
            // first rounds walk every mode with the pin low
            if (n < 4)
                ctrl[7:6] = n[1:0];
            @(posedge clk);
            pin <= (n < 4) ? 1'h0 : 1'($urandom);
            cable_ok <= 4'($urandom);
            access(CPPLR_IDX_ROUTE, 1'h1, route);
            access(CPPLR_IDX_CTRL, 1'h1, ctrl);
            access(CPPLR_IDX_STATUS, 1'h1, 8'hff);
            // pin and detector syncs need three edges, margin kept
            repeat (4) @(posedge clk);
            #1;
            e = exp_pwr(ctrl, route, pin);
            cmp_pwr(pwr, e);
            rd_chk(CPPLR_IDX_CTRL, ctrl);
            rd_chk(CPPLR_IDX_ROUTE, route);
            want = {CPPLR_RSVD_READ, cable_ok & e.input_en};
            rd_chk(CPPLR_IDX_STATUS, want);
        end
        $display("test random modes done");
        // a write while the enable is low must not land
        @(posedge clk);
        ce <= 1'h0;
        access(CPPLR_IDX_CTRL, 1'h1, ~ctrl);
        @(posedge clk);
        ce <= 1'h1;
        rd_chk(CPPLR_IDX_CTRL, ctrl);
        // a reset in mid-run brings every default back
        @(posedge clk);
        sys_rst <= 1'h1;
        repeat (3) @(posedge clk);
        sys_rst <= 1'h0;
        rd_chk(CPPLR_IDX_CTRL, CPPLR_CTRL_RST);
        rd_chk(CPPLR_IDX_ROUTE, CPPLR_ROUTE_RST);
        repeat (2) @(posedge clk);
        #1;
        e = exp_pwr(CPPLR_CTRL_RST, CPPLR_ROUTE_RST, pin);
        cmp_pwr(pwr, e);
        want = {CPPLR_RSVD_READ, cable_ok & e.input_en};
        rd_chk(CPPLR_IDX_STATUS, want);
        $display("test enable and reset done");
        close_out();
    end

    // limit: 200 rounds of 17 edges each, with ample margin
    initial
    begin
        repeat (200 * 40) @(posedge clk);
        errors++;
        close_out();
    end
endmodule

`default_nettype wire
